// ===== acsq_pkg.sv
// Constants, register map and state type of the converter sequencer.
`default_nettype none
package acsq_pkg;
  // Register byte addresses on the APB bus.
  localparam logic [7:0] ADDR_CONTROL     = 8'h00;
  localparam logic [7:0] ADDR_DIVIDER     = 8'h04;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h08;
  localparam logic [7:0] ADDR_RESULT_LOW  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS      = 8'h10;
  localparam logic [7:0] ADDR_MASK        = 8'h14;
  // Control register fields.
  localparam int CTL_ON_BIT   = 0;
  localparam int CTL_GO_BIT   = 1;
  localparam int CTL_CHAN_LSB = 2;
  localparam int CTL_CHAN_MSB = 6;
  // Status and mask fields.
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_ABORT_BIT = 1;
  // Reset values.
  localparam logic [4:0] CHAN_RESET    = 5'h00;
  localparam logic [7:0] DIVIDER_RESET = 8'h03;
  localparam logic [1:0] MASK_RESET    = 2'h0;
  // Conversion shape: result width, first trial code and last bit-period counts.
  localparam int         RESULT_WIDTH  = 10;
  localparam logic [3:0] CONV_LAST     = 4'ha;
  localparam logic [1:0] ABORT_LAST    = 2'h1;
  localparam logic [9:0] TRIAL_FIRST   = 10'h200;
  // External inputs five to seven exist on the larger package.
  localparam logic       LARGE_PACKAGE = 1'b1;
  // Sequencer states.
  typedef enum logic [1:0] {
    ST_OFF     = 2'b00,
    ST_ACQ     = 2'b01,
    ST_CONV    = 2'b10,
    ST_HOLDOFF = 2'b11
  } acsq_state_t;
endpackage : acsq_pkg
`default_nettype wire

// ===== acsq_sar_if.sv
// Interface between the sequencer control and the approximation engine.
`timescale 1ns/100ps
`default_nettype none
interface acsq_sar_if;
  logic       tick;    // One pclk pulse per converter bit period.
  logic       start;   // Begin a conversion.
  logic       abort;   // Drop the conversion without a result.
  logic       cmp;     // Synchronised comparator, high when input is at or above trial.
  logic       busy;    // Conversion running.
  logic       done;    // One-cycle pulse at normal completion.
  logic [9:0] trial;   // Code presented to the converter core.
  logic [9:0] result;  // Last completed result.
  modport ctrl (output tick, start, abort, cmp, input busy, done, trial, result);
  modport engine (input tick, start, abort, cmp, output busy, done, trial, result);
endinterface : acsq_sar_if
`default_nettype wire

// ===== acsq_tick.sv
// Converter bit-period tick generator divided down from pclk.
`timescale 1ns/100ps
`default_nettype none
module acsq_tick (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic       run,
  input  wire logic [7:0] divider,
  output var  logic       tick
);
  logic [7:0] cnt_q;  // Cycles elapsed in the current bit period.

  // Counts divider+1 cycles per period and restarts whenever run drops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        cnt_q <= 8'h00;
        tick  <= 1'b0;
      end else if (cnt_q == divider) begin
        cnt_q <= 8'h00;
        tick  <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 8'h01;
        tick  <= 1'b0;
      end
    end
  end
endmodule : acsq_tick
`default_nettype wire

// ===== acsq_sar.sv
// Successive-approximation engine resolving one bit per bit period.
`timescale 1ns/100ps
`default_nettype none
module acsq_sar (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   clk_en,
  acsq_sar_if.engine  sif
);
  logic [3:0] period_q;  // Bit periods completed in this conversion.
  logic [9:0] mask_q;    // Bit currently under trial.

  // The first period only disconnects the sampler; bits follow MSB first.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q   <= 4'h0;
      mask_q     <= 10'h000;
      sif.busy   <= 1'b0;
      sif.done   <= 1'b0;
      sif.trial  <= 10'h000;
      sif.result <= 10'h000;
    end else if (clk_en) begin
      sif.done <= 1'b0;
      if (sif.abort) begin
        // Result is left as it was.
        sif.busy <= 1'b0;
      end else if (sif.start) begin
        sif.busy  <= 1'b1;
        period_q  <= 4'h0;
        mask_q    <= acsq_pkg::TRIAL_FIRST;
        sif.trial <= acsq_pkg::TRIAL_FIRST;
      end else if (sif.busy && sif.tick) begin
        period_q <= period_q + 4'h1;
        if (period_q != 4'h0) begin
          // Keep or drop the bit under trial, then try the next one.
          sif.trial <= (sif.cmp ? sif.trial : (sif.trial & ~mask_q)) | (mask_q >> 1);
          mask_q    <= mask_q >> 1;
        end
        if (period_q == acsq_pkg::CONV_LAST) begin
          sif.busy   <= 1'b0;
          sif.done   <= 1'b1;
          sif.result <= sif.cmp ? sif.trial : (sif.trial & ~mask_q);
        end
      end
    end
  end
endmodule : acsq_sar
`default_nettype wire

// ===== acsq_top.sv
// Converter sequencer: APB registers, sequencing state machine and interrupt.
`timescale 1ns/100ps
`default_nettype none
module acsq_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        sleep_req,
  input  wire logic        cmp_in,
  output var  logic        irq,
  output var  logic        power_on,
  output var  logic        sample_close,
  output var  logic [4:0]  chan_sel,
  output var  logic        chan_valid,
  output var  logic [9:0]  dac_code
);
  acsq_sar_if sif ();

  acsq_pkg::acsq_state_t state_q;  // Sequencer state.
  logic        on_q;               // Converter enable bit.
  logic        go_q;               // Start/status bit.
  logic [4:0]  chan_q;             // Channel select field.
  logic [7:0]  div_q;              // Bit-period divider.
  logic [1:0]  stat_q;             // Sticky event bits.
  logic [1:0]  mask_q;             // Interrupt mask.
  logic [1:0]  hold_q;             // Bit periods waited after an abort.
  logic        slp1_q;             // Sleep synchroniser, first stage.
  logic        slp2_q;             // Sleep synchroniser, second stage.
  logic        slp3_q;             // Sleep synchroniser, third stage.
  logic        sleep_q;            // Accepted sleep level.
  logic        cmp1_q;             // Comparator synchroniser, first stage.
  logic        cmp2_q;             // Comparator synchroniser, second stage.
  logic        cmp3_q;             // Comparator synchroniser, third stage.
  logic        cmp_q;              // Accepted comparator level.
  logic        wr_done;            // APB write completes this edge.
  logic        rd_done;            // APB read completes this edge.
  logic        abort_ev;           // Running conversion is dropped.
  logic [31:0] rd_mux;             // Read data for the current address.
  logic        mapped;             // Address hits a register.

  // Channel codes that reach the sampler: internal or external signals.
  function automatic logic chan_routed(input logic [4:0] code);
    logic ok;
    ok = 1'b0;
    if (code[4:3] == 2'b11) begin
      ok = (code <= 5'h1c) || acsq_pkg::LARGE_PACKAGE;
    end else if (code[4] == 1'b0) begin
      ok = (code != 5'h08) && (code != 5'h09);
    end
    return ok;
  endfunction : chan_routed

  // Engine and tick generator.
  acsq_sar u_sar (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .sif     (sif.engine)
  );

  acsq_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     ((state_q == acsq_pkg::ST_CONV) || (state_q == acsq_pkg::ST_HOLDOFF)),
    .divider (div_q),
    .tick    (sif.tick)
  );

  // APB completion strobes, taken at the edge where pready is high.
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  // The running conversion is dropped once the start bit has been cleared.
  assign abort_ev  = (state_q == acsq_pkg::ST_CONV) && !go_q && !sif.done;
  assign sif.abort = abort_ev;
  assign sif.start = (state_q == acsq_pkg::ST_ACQ) && go_q;
  assign sif.cmp   = cmp_q;

  // Sleep pin passes three flops; a change counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slp1_q  <= 1'b0;
      slp2_q  <= 1'b0;
      slp3_q  <= 1'b0;
      sleep_q <= 1'b0;
    end else if (clk_en) begin
      slp1_q <= sleep_req;
      slp2_q <= slp1_q;
      slp3_q <= slp2_q;
      if (slp2_q == slp3_q) begin
        sleep_q <= slp3_q;
      end
    end
  end

  // Comparator pin is synchronised the same way.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp1_q <= 1'b0;
      cmp2_q <= 1'b0;
      cmp3_q <= 1'b0;
      cmp_q  <= 1'b0;
    end else if (clk_en) begin
      cmp1_q <= cmp_in;
      cmp2_q <= cmp1_q;
      cmp3_q <= cmp2_q;
      if (cmp2_q == cmp3_q) begin
        cmp_q <= cmp3_q;
      end
    end
  end

  // Software-written registers: control enable and channel, divider, and interrupt mask.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q   <= 1'b0;
      chan_q <= acsq_pkg::CHAN_RESET;
      div_q  <= acsq_pkg::DIVIDER_RESET;
      mask_q <= acsq_pkg::MASK_RESET;
    end else if (clk_en && wr_done) begin
      if (paddr == acsq_pkg::ADDR_CONTROL) begin
        on_q   <= pwdata[acsq_pkg::CTL_ON_BIT];
        chan_q <= pwdata[acsq_pkg::CTL_CHAN_MSB:acsq_pkg::CTL_CHAN_LSB];
      end
      if (paddr == acsq_pkg::ADDR_DIVIDER) begin
        div_q <= pwdata[7:0];
      end
      if (paddr == acsq_pkg::ADDR_MASK) begin
        mask_q <= pwdata[1:0];
      end
    end
  end

  // Start/status bit: software sets or clears it, completion clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q <= 1'b0;
    end else if (clk_en) begin
      if (sif.done || sleep_q || !on_q) begin
        // Completion, sleep or power-off always leave the bit clear.
        go_q <= 1'b0;
      end else if (wr_done && (paddr == acsq_pkg::ADDR_CONTROL)) begin
        // A start is only taken while acquiring or converting.
        go_q <= pwdata[acsq_pkg::CTL_GO_BIT] && pwdata[acsq_pkg::CTL_ON_BIT]
                && ((state_q == acsq_pkg::ST_ACQ) || (state_q == acsq_pkg::ST_CONV));
      end
    end
  end

  // Sequencing state machine.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= acsq_pkg::ST_OFF;
      hold_q  <= 2'h0;
    end else if (clk_en) begin
      unique case (state_q)
        acsq_pkg::ST_OFF: begin
          // Powered down until enabled and awake.
          if (on_q && !sleep_q) begin
            state_q <= acsq_pkg::ST_ACQ;
          end
        end
        acsq_pkg::ST_ACQ: begin
          // Sampler tracks the selected channel until a start.
          if (!on_q || sleep_q) begin
            state_q <= acsq_pkg::ST_OFF;
          end else if (go_q) begin
            state_q <= acsq_pkg::ST_CONV;
          end
        end
        acsq_pkg::ST_CONV: begin
          // Completion returns to acquisition; an abort holds off first, or goes to off if disabled or asleep.
          if (sif.done) begin
            state_q <= acsq_pkg::ST_ACQ;
          end else if (abort_ev) begin
            hold_q  <= 2'h0;
            state_q <= (on_q && !sleep_q) ? acsq_pkg::ST_HOLDOFF : acsq_pkg::ST_OFF;
          end
        end
        acsq_pkg::ST_HOLDOFF: begin
          // Two ticks pass, the first closing the bit period in progress, then acquisition restarts unprompted.
          if (!on_q || sleep_q) begin
            state_q <= acsq_pkg::ST_OFF;
          end else if (sif.tick) begin
            hold_q <= hold_q + 2'h1;
            if (hold_q == acsq_pkg::ABORT_LAST) begin
              state_q <= acsq_pkg::ST_ACQ;
            end
          end
        end
      endcase
    end
  end

  // Sticky events; a new event wins over the read that clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= 2'h0;
    end else if (clk_en) begin
      if (rd_done && (paddr == acsq_pkg::ADDR_STATUS)) begin
        stat_q <= 2'h0;
      end
      if (sif.done) begin
        stat_q[acsq_pkg::STAT_DONE_BIT] <= 1'b1;
      end
      if (abort_ev) begin
        stat_q[acsq_pkg::STAT_ABORT_BIT] <= 1'b1;
      end
    end
  end

  // Read multiplexer over the register map.
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      acsq_pkg::ADDR_CONTROL:     rd_mux[6:0] = {chan_q, go_q, on_q};
      acsq_pkg::ADDR_DIVIDER:     rd_mux[7:0] = div_q;
      acsq_pkg::ADDR_RESULT_HIGH: rd_mux[1:0] = sif.result[9:8];
      acsq_pkg::ADDR_RESULT_LOW:  rd_mux[7:0] = sif.result[7:0];
      acsq_pkg::ADDR_STATUS:      rd_mux[1:0] = stat_q;
      acsq_pkg::ADDR_MASK:        rd_mux[1:0] = mask_q;
      default:                    mapped      = 1'b0;
    endcase
  end

  // APB answer: one wait state, error on unmapped addresses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Registered outputs to the analog side and the interrupt line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq          <= 1'b0;
      power_on     <= 1'b0;
      sample_close <= 1'b0;
      chan_sel     <= acsq_pkg::CHAN_RESET;
      chan_valid   <= 1'b0;
      dac_code     <= 10'h000;
    end else if (clk_en) begin
      irq          <= |(stat_q & mask_q);
      power_on     <= on_q && !sleep_q;
      sample_close <= (state_q == acsq_pkg::ST_ACQ);
      chan_sel     <= chan_q;
      chan_valid   <= chan_routed(chan_q);
      dac_code     <= sif.trial;
    end
  end
endmodule : acsq_top
`default_nettype wire

// ===== acsq_top_sva.sv
// Port-level checker for the converter sequencer.
`timescale 1ns/100ps
`default_nettype none
module acsq_top_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sleep_req,
  input wire logic        irq,
  input wire logic        power_on,
  input wire logic        sample_close,
  input wire logic [4:0]  chan_sel,
  input wire logic        chan_valid,
  input wire logic [9:0]  dac_code
);
  // All checks run on the bus clock and stand down in reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr[1:0] != 0 || paddr > 8'h14))
    else $error("pslverr does not match the address map");
  a_chan_code: assert property ($past(presetn, 2) |-> chan_valid ==
    !(chan_sel inside {5'h08, 5'h09} || chan_sel[4:3] == 2'b10))
    else $error("chan_valid wrong for the channel code");
  a_sleep_off: assert property (sleep_req [*6] |-> !power_on)
    else $error("converter powered while sleeping");
  a_off_open: assert property (!power_on [*3] |-> !sample_close)
    else $error("sampler closed while converter off");
  a_first_trial: assert property ($fell(sample_close) && power_on |->
    ##[0:2] dac_code == 10'h200)
    else $error("first trial code is not the midpoint");
  a_hold_low: assert property ($fell(sample_close) && power_on |-> !sample_close [*3])
    else $error("sampler reconnected too soon");
  a_off_write: assert property (psel && penable && pready && pwrite &&
    paddr == 8'h00 && !pwdata[0] |-> ##[1:2] !power_on)
    else $error("enable clear did not power down");
  a_reset_quiet: assert property ($rose(presetn) |-> !power_on && !irq && !sample_close)
    else $error("outputs active right after reset");
endmodule : acsq_top_sva
bind acsq_top acsq_top_sva i_sva (.*);
`default_nettype wire

// ===== acsq_cmp_model.sv
// Behavioural hold capacitor and comparator at the converter core.
`timescale 1ns/100ps
`default_nettype none
module acsq_cmp_model (
  input  wire logic       pclk,
  input  wire logic       power_on,
  input  wire logic       sample_close,
  input  wire logic [9:0] dac_code,
  input  wire logic [9:0] level,
  output var  logic       cmp_in
);
  logic [9:0] held_q = 10'h000; // Charge held on the capacitor.
  logic       junk_q = 1'b0;    // Noise of an unpowered comparator.
  // The capacitor tracks the input only while the sampler is closed.
  always_ff @(posedge pclk) begin
    if (sample_close) held_q <= level;
    junk_q <= ~junk_q;
  end
  // With no offset, a trial equal to the held level compares high.
  always_comb cmp_in = power_on ? (held_q >= dac_code) : junk_q;
endmodule : acsq_cmp_model
`default_nettype wire

// ===== adc_conversion_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer_tb;
  // Bit period in pclk cycles, programmed through the divider before converting.
  // A trial code needs about six cycles to reach the comparator and come back
  // through its synchroniser, so shorter periods would decide on stale answers.
  localparam int TBIT = 8;
  logic        pclk = 1'b0;       // Bus clock.
  logic        presetn = 1'b0;    // Reset, active low.
  logic        psel = 1'b0;       // APB select.
  logic        penable = 1'b0;    // APB access phase.
  logic        pwrite = 1'b0;     // APB direction.
  logic [7:0]  paddr = 8'h00;     // APB address.
  logic [31:0] pwdata = 32'h0;    // APB write data.
  logic        sleep_req = 1'b0;  // Sleep request.
  logic [9:0]  level = 10'h000;   // Analog level at the selected input.
  logic [31:0] prdata;            // Read data.
  logic        pready;            // Transfer answer.
  logic        pslverr;           // Transfer error.
  logic        irq;               // Interrupt.
  logic        power_on;          // Converter powered.
  logic        sample_close;      // Sampler connected.
  logic [4:0]  chan_sel;          // Channel routed.
  logic        chan_valid;        // Channel code routes a signal.
  logic [9:0]  dac_code;          // Trial code.
  logic        cmp_in;            // Comparator answer.
  logic [31:0] rd;                // Last read data.
  logic        er;                // Last error flag.
  int          n_fail = 0;        // Mismatches.
  int          num_checks = 0;    // Comparisons.
  int          cyc = 0;           // Free cycle count.
  int          t0;                // Start time of a conversion.
  int          n;                 // Wait count.
  // Clock and cycle counter.
  initial forever #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  acsq_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .cmp_in(cmp_in), .irq(irq),
    .power_on(power_on), .sample_close(sample_close), .chan_sel(chan_sel),
    .chan_valid(chan_valid), .dac_code(dac_code));
  acsq_cmp_model i_cmp (.pclk(pclk), .power_on(power_on), .sample_close(sample_close),
    .dac_code(dac_code), .level(level), .cmp_in(cmp_in));
  // Prints the counts and the verdict, then ends the run.
  task stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Compares one value and reports a mismatch at once.
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // One APB transfer, held until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 16) begin
      n_fail++;
      stop_test();
    end
  endtask : apb
  // Reads a register and compares it.
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask : rdc
  // Powers up on channel 11000, waits acquisition, starts a conversion.
  task convert(input logic [9:0] lv);
    level <= lv;
    apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'h61);
    repeat (10) @(posedge pclk);
    apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'h63);
    t0 = cyc;
  endtask : convert
  // Polls the start bit until it reads zero, under a bound.
  task poll_done();
    int k;
    k = 0;
    do begin
      apb(1'b0, acsq_pkg::ADDR_CONTROL, 32'h0);
      k++;
    end while (rd[1] !== 1'b0 && k < 40);
    if (k >= 40) begin
      n_fail++;
      stop_test();
    end
  endtask : poll_done
  // Main sequence.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdc("reset value", 8'(4 * i), (i == 1) ? 32'h3 : 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    check("unmapped data", rd, 32'h0);
    apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'hfe);
    rdc("control bits", acsq_pkg::ADDR_CONTROL, 32'h7c);
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'(c << 2));
      repeat (2) @(posedge pclk);
      check("chan_sel", 32'(chan_sel), 32'(c));
      check("chan_valid", 32'(chan_valid), 32'(c != 8 && c != 9 && (c < 16 || c > 23)));
    end
    apb(1'b1, acsq_pkg::ADDR_DIVIDER, 32'(TBIT - 1));
    convert(10'h2c5);
    rdc("busy", acsq_pkg::ADDR_CONTROL, 32'h63);
    poll_done();
    check("duration", 32'(cyc - t0 >= 11 * TBIT && cyc - t0 < 11 * TBIT + 20), 32'h1);
    rdc("result high", acsq_pkg::ADDR_RESULT_HIGH, 32'h2);
    rdc("result low", acsq_pkg::ADDR_RESULT_LOW, 32'hc5);
    check("irq masked", 32'(irq), 32'h0);
    rdc("status done", acsq_pkg::ADDR_STATUS, 32'h1);
    rdc("status cleared", acsq_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, acsq_pkg::ADDR_MASK, 32'h3);
    convert(10'h13a);
    poll_done();
    repeat (2) @(posedge pclk);
    check("irq raised", 32'(irq), 32'h1);
    rdc("result low 2", acsq_pkg::ADDR_RESULT_LOW, 32'h3a);
    rdc("status done 2", acsq_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    check("irq cleared", 32'(irq), 32'h0);
    convert(10'h3ff);
    repeat (12) @(posedge pclk);
    apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'h61);
    n = 0;
    while (sample_close !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    check("holdoff", 32'(n > TBIT && n < 40), 32'h1);
    rdc("kept low", acsq_pkg::ADDR_RESULT_LOW, 32'h3a);
    rdc("kept high", acsq_pkg::ADDR_RESULT_HIGH, 32'h1);
    rdc("status abort", acsq_pkg::ADDR_STATUS, 32'h2);
    sleep_req <= 1'b1;
    repeat (8) @(posedge pclk);
    check("sleep power", 32'(power_on), 32'h0);
    apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'h63);
    rdc("sleep start dropped", acsq_pkg::ADDR_CONTROL, 32'h61);
    sleep_req <= 1'b0;
    repeat (8) @(posedge pclk);
    check("wake power", 32'(power_on), 32'h1);
    apb(1'b1, acsq_pkg::ADDR_CONTROL, 32'h60);
    repeat (3) @(posedge pclk);
    check("off power", 32'(power_on), 32'h0);
    check("off sampler", 32'(sample_close), 32'h0);
    convert(10'h155);
    repeat (12) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("reset power", 32'(power_on), 32'h0);
    presetn <= 1'b1;
    rdc("reset control", acsq_pkg::ADDR_CONTROL, 32'h0);
    rdc("reset result", acsq_pkg::ADDR_RESULT_LOW, 32'h0);
    stop_test();
  end
endmodule : adc_conversion_sequencer_tb
`default_nettype wire
